/* File: core/lcal_pkg.sv */
// lcal_pkg: shared constants for the laser calibration and sense command block
// assumes fixed-point slope q2.14 and signed 16-bit offsets and quantities
package lcal_pkg;
  localparam int LCAL_IDX_W      = 5;
  localparam int LCAL_NUM_IDX    = 32;
  localparam int LCAL_VAL_W      = 16;
  localparam int LCAL_FRAC       = 14;
  localparam logic [15:0] LCAL_SLOPE_ONE = 16'h4000;
  localparam logic [15:0] LCAL_OFFS_ZERO = 16'h0000;
  // slope limits 0.9 and 1.1 in q2.14, rounded inward
  localparam logic [15:0] LCAL_SLOPE_MIN = 16'h399a;
  localparam logic [15:0] LCAL_SLOPE_MAX = 16'h4666;
  // offset limit taken as 5 percent of 16-bit signed full scale (32768)
  localparam logic signed [15:0] LCAL_OFFS_LIM = 16'sh0666;
  // implemented indices: 1..20, 22, 24 and 25
  localparam logic [31:0] LCAL_IDX_MAP   = 32'h035ffffe;
  localparam logic signed [15:0] LCAL_SENSE_THR = 16'sh0200;
  localparam logic [7:0] LCAL_TERM_CHAR  = 8'h0a;
  localparam logic LCAL_EDIT_RST  = 1'b0;
  localparam logic LCAL_SENSE_RST = 1'b0;
  localparam logic LCAL_WARN_RST  = 1'b1;
  typedef enum logic [1:0] {LCAL_RSP_NONE, LCAL_RSP_ENTRY, LCAL_RSP_TERM} lcal_rsp_e;
endpackage

/* File: core/lcal_table.sv */
// lcal_table: slope and offset storage, one flip-flop entry per index
// assumes writes are already validated by the caller
`timescale 1ns/100ps
module lcal_table import lcal_pkg::*; #(
  parameter int NUM = LCAL_NUM_IDX
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire logic                  restore,
  input  wire logic [LCAL_IDX_W-1:0] wr_idx,
  input  wire logic [15:0]           wr_slope,
  input  wire logic [15:0]           wr_offs,
  input  wire logic [LCAL_IDX_W-1:0] rd_idx,
  output logic      [15:0]           rd_slope,
  output logic      [15:0]           rd_offs,
  input  wire logic [LCAL_IDX_W-1:0] rd2_idx,
  output logic      [15:0]           rd2_slope,
  output logic      [15:0]           rd2_offs
);
  logic [15:0] slope_q [NUM];
  logic [15:0] offs_q  [NUM];

  for (genvar i = 0; i < NUM; i++) begin : g_ent
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        slope_q[i] <= LCAL_SLOPE_ONE;
        offs_q[i]  <= LCAL_OFFS_ZERO;
      end else if (restore) begin
        slope_q[i] <= LCAL_SLOPE_ONE;
        offs_q[i]  <= LCAL_OFFS_ZERO;
      end else if (wr_en && wr_idx == LCAL_IDX_W'(i)) begin
        slope_q[i] <= wr_slope;
        offs_q[i]  <= wr_offs;
      end
    end
  end

  assign rd_slope = slope_q[rd_idx];
  assign rd_offs  = offs_q[rd_idx];
  // second port feeds the compensation datapath without arbitration
  assign rd2_slope = slope_q[rd2_idx];
  assign rd2_offs  = offs_q[rd2_idx];
endmodule

/* File: core/lcal_comp.sv */
// lcal_comp: compensated = slope * raw + offset, registered, saturating
// assumes q2.14 slope and signed 16-bit raw and offset
`timescale 1ns/100ps
module lcal_comp import lcal_pkg::*; (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [15:0]        slope,
  input  wire logic [15:0]        offs,
  input  wire logic signed [15:0] raw,
  output logic signed [15:0]      comp_q
);
  logic signed [32:0] prod;
  logic signed [18:0] sum;

  always_comb begin
    prod = $signed({1'b0, slope}) * raw;
    sum  = 19'(prod >>> LCAL_FRAC) + 19'(signed'(offs));
  end

  // saturate rather than wrap so a bad entry cannot flip the sign
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) comp_q <= '0;
    else if (sum > 19'sd32767) comp_q <= 16'sh7fff;
    else if (sum < -19'sd32768) comp_q <= 16'sh8000;
    else comp_q <= sum[15:0];
  end
endmodule

/* File: core/lcal_cmd.sv */
// lcal_cmd: decoded-command handler for trigger, calibration table and voltage sense
// assumes a parser upstream presents one-cycle command strobes with arguments
// Functional notes
// - trigger command acts as one trigger edge
// - trigger only with pulsed output capability
// - reject calibration writes while edit disabled
// - edit flag clears on reset command, power
// - edit argument: 0 disables, 1 enables
// - one edit flag for all channels
// - edit query returns 0 or 1
// - entry query returns slope and offset
// - all-query dumps every implemented index, optional terminators
// - entries default slope 1, offset 0
// - compensated equals slope times raw plus offset
// - index map: set points, measurements, auxiliaries
// - reject writes to unimplemented indices
// - restore command resets all entries
// - sense select: 0 local, 1 remote
// - sense query returns stored selection
// - remote mode compares local and remote voltages
// - warning enable: 0 suppress, 1 allow
`timescale 1ns/100ps
module lcal_cmd import lcal_pkg::*; #(
  parameter bit HAS_PULSED = 1'b1,
  parameter bit HAS_SENSE  = 1'b1,
  parameter logic [31:0] IDX_MAP = LCAL_IDX_MAP
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  inst_reset_cmd,
  input  wire logic                  trigger_cmd,
  input  wire logic                  ext_trigger_in,
  input  wire logic                  cal_edit_enable_cmd,
  input  wire logic                  cal_edit_arg,
  input  wire logic                  cal_edit_query,
  input  wire logic                  cal_entry_write,
  input  wire logic [LCAL_IDX_W-1:0] cmd_idx,
  input  wire logic [15:0]           cmd_slope,
  input  wire logic [15:0]           cmd_offs,
  input  wire logic                  cal_entry_query,
  input  wire logic                  cal_all_query,
  input  wire logic                  cal_all_term,
  input  wire logic                  cal_factory_restore,
  input  wire logic                  sense_select_cmd,
  input  wire logic                  sense_select_arg,
  input  wire logic                  sense_query,
  input  wire logic                  sense_warning_enable_cmd,
  input  wire logic                  sense_warning_arg,
  input  wire logic [LCAL_IDX_W-1:0] comp_idx,
  input  wire logic signed [15:0]    comp_raw,
  input  wire logic signed [15:0]    v_local,
  input  wire logic signed [15:0]    v_remote,
  output logic                       pulsed_trigger_q,
  output logic                       cmd_err_q,
  output logic                       cal_edit_q,
  output logic                       sense_remote_q,
  output logic                       sense_warn_en_q,
  output logic                       warn_800_q,
  output logic                       rsp_valid_q,
  output lcal_rsp_e                  rsp_kind_q,
  output logic [LCAL_IDX_W-1:0]      rsp_idx_q,
  output logic [15:0]                rsp_slope_q,
  output logic [15:0]                rsp_offs_q,
  output logic                       rsp_bit_q,
  output logic [7:0]                 rsp_char_q,
  output logic                       rsp_last_q,
  output logic                       busy_q,
  output logic signed [15:0]         comp_out_q
);
  typedef enum logic [1:0] {LCAL_IDLE, LCAL_DUMP, LCAL_TERM} lcal_dump_e;
  lcal_dump_e                dump_q;
  logic [LCAL_IDX_W-1:0]     dump_idx_q;
  logic                      dump_term_q;
  logic                      ext_q;
  logic                      wr_ok;
  logic                      range_ok;
  logic                      dump_next;
  logic [LCAL_IDX_W-1:0]     rd_idx;
  logic [15:0]               rd_slope;
  logic [15:0]               rd_offs;
  logic [15:0]               comp_slope;
  logic [15:0]               comp_offs;
  logic signed [16:0]        vdiff;
  logic                      dump_busy;

  assign dump_busy = (dump_q != LCAL_IDLE);

  always_comb begin
    range_ok = (cmd_slope >= LCAL_SLOPE_MIN) && (cmd_slope <= LCAL_SLOPE_MAX) &&
               ($signed(cmd_offs) <= LCAL_OFFS_LIM) &&
               ($signed(cmd_offs) >= -LCAL_OFFS_LIM);
    wr_ok = cal_entry_write && cal_edit_q && IDX_MAP[cmd_idx] && range_ok;
  end

  // query and dump reads share the first port: a dump owns it, otherwise the query index
  always_comb begin
    rd_idx = dump_busy ? dump_idx_q : cmd_idx;
  end

  lcal_table u_table (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wr_en     (wr_ok),
    .restore   (cal_factory_restore),
    .wr_idx    (cmd_idx),
    .wr_slope  (cmd_slope),
    .wr_offs   (cmd_offs),
    .rd_idx    (rd_idx),
    .rd_slope  (rd_slope),
    .rd_offs   (rd_offs),
    .rd2_idx   (comp_idx),
    .rd2_slope (comp_slope),
    .rd2_offs  (comp_offs)
  );

  // own read port, so a long dump never stalls the compensated value
  lcal_comp u_comp (
    .clk     (clk),
    .sys_rst (sys_rst),
    .slope   (comp_slope),
    .offs    (comp_offs),
    .raw     (comp_raw),
    .comp_q  (comp_out_q)
  );

  logic                      ext_rise;
  logic [16:0]               vmag;
  logic                      big;
  logic [31:0]               rest;
  logic                      more;
  logic                      here;
  logic                      sense_cmd_any;
  logic                      query_any;

  // trigger path: the command and a pin edge share one pulse
  assign ext_rise = ext_trigger_in && !ext_q;

  // idle level of the pin is low, so no false edge follows reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_trigger_in;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulsed_trigger_q <= 1'b0;
    end else if (HAS_PULSED) begin
      pulsed_trigger_q <= trigger_cmd || ext_rise;
    end else begin
      pulsed_trigger_q <= 1'b0;
    end
  end

  // edit interlock: one system-wide flag, no per-channel copy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_edit_q <= LCAL_EDIT_RST;
    end else if (inst_reset_cmd) begin
      cal_edit_q <= LCAL_EDIT_RST;
    end else if (cal_edit_enable_cmd) begin
      cal_edit_q <= cal_edit_arg;
    end
  end

  // sense selection, only on variants with four-wire sensing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sense_remote_q <= LCAL_SENSE_RST;
    end else if (sense_select_cmd && HAS_SENSE) begin
      sense_remote_q <= sense_select_arg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sense_warn_en_q <= LCAL_WARN_RST;
    end else if (sense_warning_enable_cmd && HAS_SENSE) begin
      sense_warn_en_q <= sense_warning_arg;
    end
  end

  // one extra bit keeps the difference of two full-scale values exact
  always_comb begin
    vdiff = 17'(v_local) - 17'(v_remote);
    if (vdiff[16]) begin
      vmag = 17'(-vdiff);
    end else begin
      vmag = 17'(vdiff);
    end
    big = vmag > {1'b0, LCAL_SENSE_THR};
  end

  // the warning is a level: it drops once the discrepancy goes away
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      warn_800_q <= 1'b0;
    end else begin
      warn_800_q <= HAS_SENSE && sense_remote_q && sense_warn_en_q && big;
    end
  end

  // error pulse for refused commands
  always_comb begin
    sense_cmd_any = sense_select_cmd || sense_warning_enable_cmd || sense_query;
    query_any     = cal_entry_query || cal_edit_query || sense_query || cal_all_query;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_err_q <= 1'b0;
    end else begin
      cmd_err_q <= (cal_entry_write && !wr_ok) ||
                   (trigger_cmd && !HAS_PULSED) ||
                   (sense_cmd_any && !HAS_SENSE) ||
                   (query_any && dump_busy);
    end
  end

  // dump walk: one index a cycle, two per implemented index with terminators; unimplemented indices are skipped
  always_comb begin
    rest      = IDX_MAP >> dump_idx_q;
    more      = |rest[31:1];
    here      = IDX_MAP[dump_idx_q];
    dump_next = ((dump_q == LCAL_DUMP) && !(here && dump_term_q) && more) ||
                ((dump_q == LCAL_TERM) && more);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dump_q      <= LCAL_IDLE;
      dump_idx_q  <= '0;
      dump_term_q <= 1'b0;
      busy_q      <= 1'b0;
    end else begin
      case (dump_q)
        LCAL_IDLE: begin
          if (cal_all_query) begin
            dump_q      <= LCAL_DUMP;
            dump_idx_q  <= '0;
            dump_term_q <= cal_all_term;
            busy_q      <= 1'b1;
          end
        end
        LCAL_DUMP: begin
          if (here && dump_term_q) begin
            dump_q <= LCAL_TERM;
          end else if (!more) begin
            dump_q <= LCAL_IDLE;
            busy_q <= 1'b0;
          end
        end
        LCAL_TERM: begin
          if (more) begin
            dump_q <= LCAL_DUMP;
          end else begin
            dump_q <= LCAL_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          dump_q <= LCAL_IDLE;
          busy_q <= 1'b0;
        end
      endcase
      if (dump_next) begin
        dump_idx_q <= LCAL_IDX_W'(dump_idx_q + 1'b1);
      end
    end
  end

  // response word: data fields hold until the next response
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_kind_q  <= LCAL_RSP_NONE;
      rsp_idx_q   <= '0;
      rsp_slope_q <= '0;
      rsp_offs_q  <= '0;
      rsp_bit_q   <= 1'b0;
      rsp_char_q  <= '0;
      rsp_last_q  <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
      if ((dump_q == LCAL_DUMP) && here) begin
        rsp_valid_q <= 1'b1;
        rsp_kind_q  <= LCAL_RSP_ENTRY;
        rsp_idx_q   <= dump_idx_q;
        rsp_slope_q <= rd_slope;
        rsp_offs_q  <= rd_offs;
        rsp_last_q  <= !dump_term_q && !more;
      end else if (dump_q == LCAL_TERM) begin
        rsp_valid_q <= 1'b1;
        rsp_kind_q  <= LCAL_RSP_TERM;
        rsp_char_q  <= LCAL_TERM_CHAR;
        rsp_last_q  <= !more;
      end else if (!dump_busy && cal_entry_query) begin
        rsp_valid_q <= 1'b1;
        rsp_kind_q  <= LCAL_RSP_ENTRY;
        rsp_idx_q   <= cmd_idx;
        rsp_slope_q <= rd_slope;
        rsp_offs_q  <= rd_offs;
        rsp_last_q  <= 1'b1;
      end else if (!dump_busy && cal_edit_query) begin
        rsp_valid_q <= 1'b1;
        rsp_kind_q  <= LCAL_RSP_NONE;
        rsp_bit_q   <= cal_edit_q;
        rsp_last_q  <= 1'b1;
      end else if (!dump_busy && sense_query && HAS_SENSE) begin
        rsp_valid_q <= 1'b1;
        rsp_kind_q  <= LCAL_RSP_NONE;
        rsp_bit_q   <= sense_remote_q;
        rsp_last_q  <= 1'b1;
      end
    end
  end
endmodule

/* File: tb/lcal_cmd_properties.sv */
// checker on lcal_cmd ports
// assumes one-cycle strobes and results within three cycles
`timescale 1ns/100ps
module lcal_cmd_chk (
  input wire logic clk, sys_rst, inst_reset_cmd, trigger_cmd, cal_edit_enable_cmd,
  input wire logic cal_edit_arg, cal_entry_write, sense_select_cmd, sense_select_arg,
  input wire logic sense_warning_enable_cmd, sense_warning_arg, pulsed_trigger_q,
  input wire logic cmd_err_q, cal_edit_q, sense_remote_q, sense_warn_en_q, warn_800_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_on; cal_edit_enable_cmd && cal_edit_arg; endsequence
  property p_on; s_on |-> ##[1:3] cal_edit_q; endproperty
  a_on: assert property (p_on) else $error("edit not set");
  property p_trig; trigger_cmd |-> ##[1:3] pulsed_trigger_q; endproperty
  a_trig: assert property (p_trig) else $error("no trigger");
  property p_lock; cal_entry_write && !cal_edit_q |-> ##[1:3] cmd_err_q; endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");
  property p_rst; inst_reset_cmd |-> ##[1:3] !cal_edit_q; endproperty
  a_rst: assert property (p_rst) else $error("edit kept");
  property p_hold; (!cal_edit_enable_cmd && !inst_reset_cmd) [*4] |-> $stable(cal_edit_q);
  endproperty
  a_hold: assert property (p_hold) else $error("edit moved");
  property p_rem; sense_select_cmd && sense_select_arg |-> ##[1:3] sense_remote_q; endproperty
  a_rem: assert property (p_rem) else $error("not remote");
  property p_off; sense_warning_enable_cmd && !sense_warning_arg |-> ##[1:3] !sense_warn_en_q;
  endproperty
  a_off: assert property (p_off) else $error("warn kept");
  property p_quiet; (!sense_remote_q || !sense_warn_en_q) [*4] |-> !warn_800_q; endproperty
  a_quiet: assert property (p_quiet) else $error("stray warning");
endmodule
bind lcal_cmd lcal_cmd_chk u_chk (.*);

/* File: tb/lcal_host.sv */
// host model: turns a command code into one strobe
// assumes code 0 is idle
`timescale 1ns/100ps
module lcal_host (
  input  wire logic [3:0]  op,
  output logic      [10:0] strb
);
  assign strb = (op == 4'h0) ? 11'h000 : 11'h001 << (op - 4'h1);
endmodule

/* File: tb/tb_lcal_cmd.sv */
// bench for lcal_cmd
// assumes results settle within four cycles
`timescale 1ns/100ps
module tb_lcal_cmd import lcal_pkg::*; ;
  logic clk = 1'h0, sys_rst = 1'h1, ext_trigger_in = 1'h0, cal_all_term = 1'h0, seen, seen_trig;
  logic cal_edit_arg = 1'h0, sense_select_arg = 1'h0, sense_warning_arg = 1'h0;
  logic [3:0] op = 4'h0;
  logic [4:0] cmd_idx = 5'h0, comp_idx = 5'h0, rsp_idx_q;
  logic [15:0] cmd_slope = 16'h0, cmd_offs = 16'h0, rsp_slope_q, rsp_offs_q;
  logic signed [15:0] comp_raw = 16'sh0, v_local = 16'sh0, v_remote = 16'sh0, comp_out_q;
  logic inst_reset_cmd, trigger_cmd, cal_edit_enable_cmd, cal_edit_query, cal_entry_write;
  logic cal_entry_query, cal_all_query, cal_factory_restore, sense_select_cmd, sense_query;
  logic sense_warning_enable_cmd, pulsed_trigger_q, cmd_err_q, cal_edit_q, sense_remote_q;
  logic sense_warn_en_q, warn_800_q, rsp_valid_q, rsp_bit_q, rsp_last_q, busy_q;
  logic [7:0] rsp_char_q;
  logic [10:0] strb;
  lcal_rsp_e rsp_kind_q;
  int err_count = 0, checks_done = 0;
  // code, argument, then expected edit, remote, warning enable
  logic [7:0] rows [8] = '{8'h3d, 8'h11, 8'h3d, 8'h31, 8'h9b, 8'hb2, 8'hbb, 8'h91};
  lcal_host host (.op(op), .strb(strb));
  assign {sense_warning_enable_cmd, sense_query, sense_select_cmd, cal_factory_restore,
    cal_all_query, cal_entry_query, cal_entry_write, cal_edit_query,
    cal_edit_enable_cmd, trigger_cmd, inst_reset_cmd} = strb;
  lcal_cmd DUT (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic a);
    @(posedge clk);
    op <= c;
    // code 0 stands for a rising edge on the external trigger pin
    ext_trigger_in <= (c == 4'h0);
    {cal_edit_arg, sense_select_arg, sense_warning_arg} <= {3{a}};
    @(posedge clk);
    op <= 4'h0;
    ext_trigger_in <= 1'h0;
    seen = 1'h0;
    seen_trig = 1'h0;
    repeat (4) begin
      @(negedge clk);
      seen |= cmd_err_q;
      seen_trig |= pulsed_trigger_q;
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] s, o, input logic e);
    @(posedge clk);
    cmd_idx <= i;
    cmd_slope <= s;
    cmd_offs <= o;
    cmd(4'h5, 1'h0);
    chk(16'(seen), 16'(e));
  endtask
  task automatic query(input logic [4:0] i, input logic [15:0] s, o);
    @(posedge clk);
    cmd_idx <= i;
    cmd(4'h6, 1'h0);
    chk(16'(rsp_idx_q), 16'(i));
    chk(rsp_slope_q, s);
    chk(rsp_offs_q, o);
  endtask
  // all-query: count entries and terminators until the last flag, bounded
  task automatic dump(input logic t, input int ne, input int nt);
    int ce;
    int ct;
    logic done;
    ce = 0;
    ct = 0;
    done = 1'h0;
    @(posedge clk);
    op <= 4'h7;
    cal_all_term <= t;
    @(posedge clk);
    op <= 4'h0;
    for (int n = 0; n < 200 && !done; n++) begin
      @(negedge clk);
      if (n == 0) chk(16'(busy_q), 16'h1);
      if (rsp_valid_q && rsp_kind_q == LCAL_RSP_ENTRY) ce++;
      if (rsp_valid_q && rsp_kind_q == LCAL_RSP_TERM && rsp_char_q == LCAL_TERM_CHAR) ct++;
      done = rsp_valid_q && rsp_last_q;
    end
    chk(16'(done), 16'h1);
    chk(16'(ce), 16'(ne));
    chk(16'(ct), 16'(nt));
    chk(16'(busy_q), 16'h0);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    chk(16'({cal_edit_q, sense_remote_q, sense_warn_en_q}), 16'h1);
    foreach (rows[k]) begin
      cmd(rows[k][7:4], rows[k][3]);
      chk(16'({cal_edit_q, sense_remote_q, sense_warn_en_q}), 16'(rows[k][2:0]));
    end
    query(5'h3, 16'h4000, 16'h0);
    wr(5'h3, 16'h4100, 16'h10, 1'h1);
    cmd(4'h3, 1'h1);
    wr(5'h3, 16'h4100, 16'h10, 1'h0);
    wr(5'h3, 16'h3000, 16'h0, 1'h1);
    wr(5'h15, 16'h4000, 16'h0, 1'h1);
    query(5'h3, 16'h4100, 16'h10);
    cmd(4'h4, 1'h0);
    chk(16'(rsp_bit_q), 16'h1);
    @(posedge clk);
    comp_idx <= 5'h3;
    comp_raw <= 16'sh1000;
    cmd(4'h2, 1'h0);
    chk(16'(seen_trig), 16'h1);
    chk(comp_out_q, 16'h1050);
    cmd(4'h0, 1'h0);
    chk(16'(seen_trig), 16'h1);
    cmd(4'h9, 1'h1);
    cmd(4'ha, 1'h0);
    chk(16'(rsp_bit_q), 16'h1);
    @(posedge clk);
    v_remote <= 16'sh1000;
    cmd(4'hb, 1'h1);
    chk(16'(warn_800_q), 16'h1);
    cmd(4'hb, 1'h0);
    chk(16'(warn_800_q), 16'h0);
    cmd(4'h8, 1'h0);
    query(5'h3, 16'h4000, 16'h0);
    dump(1'h0, 23, 0);
    dump(1'h1, 23, 23);
    cmd(4'h3, 1'h1);
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    chk(16'({cal_edit_q, sense_remote_q, sense_warn_en_q}), 16'h1);
    give_verdict;
  end
endmodule
